// [logic/rtc_calendar_counters.sv]
// Calendar counter chain with divider stages behind an AXI4-Lite slave
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "rtc_calendar_defines.svh"

module rtc_calendar_counters
    import rtc_calendar_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_clk_en,
    input  wire logic [5:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [5:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);

    // ======================================================================
    // Helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic leap);
        unique case (m)
            8'h02:                      last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default:                    last_day = 8'h31;
        endcase
    endfunction

    // ======================================================================
    // Declarations
    // Power-up values only; i_resetn never loads them, so time survives resets
    calendar_type cal = '0;
    logic [6:0]   div = 7'h00;
    logic [17:0]  presc;
    logic         start;
    logic         tick;
    logic         div_step;
    logic         div_clear;
    logic         sec_step;
    logic         sec_carry;
    logic         min_carry;
    logic         day_carry;
    logic         mon_carry;
    logic         leap;
    logic         wr_fire;
    logic [3:0]   wr_idx;
    logic [8:0]   wr_hit;
    logic [7:0]   wbyte;
    logic [3:0]   rd_idx;
    logic [7:0]   rd_byte;

    // ======================================================================
    // Bus slave, write side
    assign o_awready = i_clk_en && i_awvalid && i_wvalid && !o_bvalid;
    assign o_wready  = o_awready;
    assign wr_fire   = o_awready;
    assign wr_idx    = i_awaddr[5:2];
    assign wbyte     = i_wdata[7:0];

    always_comb begin
        for (int k = 0; k < 9; k++) begin
            wr_hit[k] = wr_fire && i_wstrb[0] && (wr_idx == 4'(k));
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp  <= `RTC_RESP_OKAY;
        end else if (i_clk_en) begin
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                o_bresp  <= (wr_idx > `RTC_IDX_CTRL) ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Bus slave, read side
    assign o_arready = i_clk_en && !o_rvalid;
    assign rd_idx    = i_araddr[5:2];

    always_comb begin
        unique case (rd_idx)
            `RTC_IDX_DIV:  rd_byte = {1'b0, div};                                  // R01 R04
            `RTC_IDX_SEC:  rd_byte = cal.sec & `RTC_MASK_SEC;                      // R17
            `RTC_IDX_MIN:  rd_byte = cal.min & `RTC_MASK_MIN;
            `RTC_IDX_HOUR: rd_byte = cal.hour & `RTC_MASK_HOUR;
            `RTC_IDX_WDAY: rd_byte = cal.wday & `RTC_MASK_WDAY;
            `RTC_IDX_DATE: rd_byte = cal.date & `RTC_MASK_DATE;
            `RTC_IDX_MON:  rd_byte = cal.mon & `RTC_MASK_MON;
            `RTC_IDX_YEAR: rd_byte = cal.year;
            `RTC_IDX_CTRL: rd_byte = {7'h00, start};
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h00000000;
            o_rresp  <= `RTC_RESP_OKAY;
        end else if (i_clk_en) begin
            if (o_arready && i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rdata  <= {24'h000000, rd_byte};
                o_rresp  <= (rd_idx > `RTC_IDX_CTRL) ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Control: start bit, reset and adjust strobes
    assign div_clear = wr_hit[`RTC_IDX_CTRL]
                       && (wbyte[`RTC_CTRL_RESET] || wbyte[`RTC_CTRL_ADJUST]);   // R02

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            start <= `RTC_START_RESET;
        end else if (i_clk_en && wr_hit[`RTC_IDX_CTRL]) begin
            start <= wbyte[`RTC_CTRL_START];
        end
    end

    // ======================================================================
    // Prescaler from the core clock down to the 128 Hz divider input
    assign tick = (presc == 18'(TICK_CYCLES - 1));

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            presc <= 18'h00000;
        end else if (i_clk_en) begin
            if (tick || div_clear) begin
                presc <= 18'h00000;
            end else begin
                presc <= presc + 18'h00001;
            end
        end
    end

    // ======================================================================
    // Divider stages, never touched by i_resetn so time survives it; the control reset bit clears them
    assign div_step = start && tick && !div_clear;
    assign sec_step = div_step && (div == `RTC_DIV_MAX);

    always_ff @(posedge i_core_clk) begin                                  // R03
        if (i_clk_en) begin
            if (div_clear) begin
                div <= 7'h00;                                              // R02
            end else if (div_step) begin
                div <= div + 7'h01;                                        // R01
            end
        end
    end

    // ======================================================================
    // Carry chain
    // Year modulo 4 equals (2 * tens + ones) modulo 4 in BCD
    assign leap      = (2'({cal.year[4], 1'b0} + cal.year[1:0]) == 2'h0);  // R13
    assign sec_carry = sec_step && (cal.sec == `RTC_SEC_MAX);              // R05
    assign min_carry = sec_carry && (cal.min == `RTC_MIN_MAX);             // R06
    assign day_carry = min_carry && (cal.hour == `RTC_HOUR_MAX);           // R07
    assign mon_carry = day_carry && (cal.date == last_day(cal.mon, leap)); // R10 R16

    // ======================================================================
    // Calendar counters; a write in the same cycle wins over a count,
    // since software is expected to have stopped counting first
    always_ff @(posedge i_core_clk) begin                                  // R03 R14
        if (i_clk_en) begin
            if (wr_hit[`RTC_IDX_SEC]) begin
                cal.sec <= wbyte & `RTC_MASK_SEC;                          // R17 R18
            end else if (sec_step) begin
                cal.sec <= sec_carry ? 8'h00 : bcd_inc(cal.sec);           // R05
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            if (wr_hit[`RTC_IDX_MIN]) begin
                cal.min <= wbyte & `RTC_MASK_MIN;                          // R17
            end else if (sec_carry) begin
                cal.min <= min_carry ? 8'h00 : bcd_inc(cal.min);           // R06
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            if (wr_hit[`RTC_IDX_HOUR]) begin
                cal.hour <= wbyte & `RTC_MASK_HOUR;                        // R17
            end else if (min_carry) begin
                cal.hour <= day_carry ? 8'h00 : bcd_inc(cal.hour);         // R07
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            if (wr_hit[`RTC_IDX_WDAY]) begin
                cal.wday <= wbyte & `RTC_MASK_WDAY;                        // R17
            end else if (day_carry) begin
                cal.wday <= (cal.wday == `RTC_WDAY_MAX) ? 8'h00 : cal.wday + 8'h01; // R08
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            if (wr_hit[`RTC_IDX_DATE]) begin
                cal.date <= wbyte & `RTC_MASK_DATE;                        // R17
            end else if (day_carry) begin
                cal.date <= mon_carry ? `RTC_FIRST : bcd_inc(cal.date);    // R09 R16
            end
        end
    end

    // Month 00 is settable and counts on to 01 like any other month
    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            if (wr_hit[`RTC_IDX_MON]) begin
                cal.mon <= wbyte & `RTC_MASK_MON;                          // R17
            end else if (mon_carry) begin
                cal.mon <= (cal.mon == `RTC_MON_MAX) ? `RTC_FIRST : bcd_inc(cal.mon); // R11
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            if (wr_hit[`RTC_IDX_YEAR]) begin
                cal.year <= wbyte;
            end else if (mon_carry && (cal.mon == `RTC_MON_MAX)) begin
                cal.year <= (cal.year == `RTC_YEAR_MAX) ? 8'h00 : bcd_inc(cal.year); // R12
            end
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    logic wr_any;
    assign wr_any = wr_fire && i_wstrb[0];

    property p_div_read_bit7;
        o_arready && i_arvalid && rd_idx == `RTC_IDX_DIV |=> o_rvalid && o_rdata[7] == 1'b0;
    endproperty
    a_div_read_bit7: assert property (p_div_read_bit7) else $error("divider bit 7 read high"); // R04

    property p_div_clear;
        i_clk_en && div_clear |=> div == 7'h00;
    endproperty
    a_div_clear: assert property (p_div_clear) else $error("divider not cleared"); // R02

    property p_div_count;
        i_clk_en && div_step |=> div == $past(div) + 7'h01;
    endproperty
    a_div_count: assert property (p_div_count) else $error("divider did not step"); // R01

    property p_reset_keeps;
        disable iff (1'b0) !i_resetn && i_clk_en && !wr_any && !div_step |=> $stable(cal) && $stable(div);
    endproperty
    a_reset_keeps: assert property (p_reset_keeps) else $error("reset altered counters"); // R03

    property p_sec_wrap;
        i_clk_en && sec_step && cal.sec == 8'h59 && !wr_any
            |=> cal.sec == 8'h00 && cal.min != $past(cal.min);
    endproperty
    a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap wrong"); // R05

    property p_min_tens;
        i_clk_en && sec_carry && cal.min == 8'h09 && !wr_any |=> cal.min == 8'h10;
    endproperty
    a_min_tens: assert property (p_min_tens) else $error("minutes digit carry wrong"); // R06

    property p_hour_wrap;
        i_clk_en && min_carry && cal.hour == 8'h23 && !wr_any |=> cal.hour == 8'h00;
    endproperty
    a_hour_wrap: assert property (p_hour_wrap) else $error("hours wrap wrong"); // R07

    property p_wday_wrap;
        i_clk_en && day_carry && cal.wday == 8'h06 && !wr_any |=> cal.wday == 8'h00;
    endproperty
    a_wday_wrap: assert property (p_wday_wrap) else $error("weekday wrap wrong"); // R08

    property p_feb_leap;
        i_clk_en && day_carry && cal.mon == 8'h02 && cal.date == 8'h28 && leap && !wr_any
            |=> cal.date == 8'h29 && cal.mon == 8'h02;
    endproperty
    a_feb_leap: assert property (p_feb_leap) else $error("leap February cut short"); // R13

    property p_feb_plain;
        i_clk_en && day_carry && cal.mon == 8'h02 && cal.date == 8'h28 && !leap && !wr_any
            |=> cal.date == 8'h01 && cal.mon == 8'h03;
    endproperty
    a_feb_plain: assert property (p_feb_plain) else $error("February rollover wrong"); // R16

    property p_apr_end;
        i_clk_en && day_carry && cal.mon == 8'h04 && cal.date == 8'h30 && !wr_any
            |=> cal.date == 8'h01 && cal.mon == 8'h05;
    endproperty
    a_apr_end: assert property (p_apr_end) else $error("30-day month rollover wrong"); // R10

    property p_year_step;
        i_clk_en && mon_carry && cal.mon == 8'h12 && !wr_any
            |=> cal.mon == 8'h01 && cal.year != $past(cal.year);
    endproperty
    a_year_step: assert property (p_year_step) else $error("year did not advance"); // R12

    property p_hour_mask;
        wr_hit[`RTC_IDX_HOUR] && i_clk_en |=> cal.hour[7:6] == 2'h0;
    endproperty
    a_hour_mask: assert property (p_hour_mask) else $error("hour upper bits kept"); // R17

    property p_stopped_hold;
        !start && !wr_any |=> $stable(div) && $stable(cal.sec);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) else $error("counted while stopped"); // R05

    c_sec_carry:  cover property (i_clk_en && sec_carry);
    c_year_carry: cover property (i_clk_en && mon_carry && cal.mon == 8'h12);
    c_div_clear:  cover property (i_clk_en && div_clear);
    c_read:       cover property (o_rvalid && i_rready);

endmodule

// [logic/rtc_calendar_defines.svh]
// Offsets, field masks, limits and timing counts of the calendar counter block
//
// Summary of operation
// [R01] Divider count exposes 64 Hz..1 Hz stages
// [R02] Reset or adjust write clears divider count
// [R03] Resets never alter divider or calendar counters
// [R04] Divider count bit 7 reads zero
// [R05] Seconds BCD 00-59, carries into minutes
// [R06] Minutes BCD 00-59, carries into hours
// [R07] Hours BCD 00-23, produces daily carry
// [R08] Weekday 0-6 Sunday first, wraps daily
// [R09] Date BCD 01-31, advances on daily carry
// [R10] Last date depends on month and leap
// [R11] Month BCD, steps on date carry
// [R12] Year BCD 00-99, steps on month carry
// [R13] Leap year when year divisible by four
// [R14] Software stops counting before writing counters
// [R15] Software writes only in-range BCD values
// [R16] Month lengths 31/30/28, February 29 leap
// [R17] Unused upper bits read zero
// [R18] Ones digit low nibble, tens above
`ifndef RTC_CALENDAR_DEFINES_SVH
`define RTC_CALENDAR_DEFINES_SVH

// ==========================================================================
// Register indices, byte address is four times the index
`define RTC_IDX_DIV      4'h0
`define RTC_IDX_SEC      4'h1
`define RTC_IDX_MIN      4'h2
`define RTC_IDX_HOUR     4'h3
`define RTC_IDX_WDAY     4'h4
`define RTC_IDX_DATE     4'h5
`define RTC_IDX_MON      4'h6
`define RTC_IDX_YEAR     4'h7
`define RTC_IDX_CTRL     4'h8

// ==========================================================================
// Writable field masks
`define RTC_MASK_DIV     8'h7F
`define RTC_MASK_SEC     8'h7F
`define RTC_MASK_MIN     8'h7F
`define RTC_MASK_HOUR    8'h3F
`define RTC_MASK_WDAY    8'h07
`define RTC_MASK_DATE    8'h3F
`define RTC_MASK_MON     8'h1F
`define RTC_MASK_YEAR    8'hFF

// ==========================================================================
// Counter limits in BCD, divider limit in binary
`define RTC_SEC_MAX      8'h59
`define RTC_MIN_MAX      8'h59
`define RTC_HOUR_MAX     8'h23
`define RTC_WDAY_MAX     8'h06
`define RTC_MON_MAX      8'h12
`define RTC_YEAR_MAX     8'h99
`define RTC_FIRST        8'h01
`define RTC_DIV_MAX      7'h7F

// ==========================================================================
// Control register bits
`define RTC_CTRL_START   0
`define RTC_CTRL_RESET   1
`define RTC_CTRL_ADJUST  2
`define RTC_START_RESET  1'b1

// ==========================================================================
// Bus responses
`define RTC_RESP_OKAY    2'h0
`define RTC_RESP_SLVERR  2'h2

// ==========================================================================
// Timing: divider input runs at 128 Hz so bit 0 toggles at 64 Hz
`define RTC_CLK_PERIOD_NS  50
`define RTC_TICK_PERIOD_NS 7812500
`define RTC_TICK_CYCLES    (`RTC_TICK_PERIOD_NS / `RTC_CLK_PERIOD_NS)

`endif

// [logic/rtc_calendar_pkg.sv]
// Types shared by the calendar counter block
package rtc_calendar_pkg;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] mon;
        logic [7:0] year;
    } calendar_type;

endpackage

// [tb/testbench.sv]
// Self-checking bench for the calendar counter chain over AXI4-Lite
`timescale 1ns/100ps
`include "rtc_calendar_defines.svh"

module testbench;

    // ==========================================================================
    // Clock, reset and bus signals
    logic        i_core_clk = 1'b0;
    logic        i_resetn   = 1'b0;
    logic        i_clk_en   = 1'b1;
    logic [5:0]  i_awaddr   = 6'h00;
    logic        i_awvalid  = 1'b0;
    logic [31:0] i_wdata    = 32'h0;
    logic [3:0]  i_wstrb    = 4'hF;
    logic        i_wvalid   = 1'b0;
    logic        i_bready   = 1'b0;
    logic [5:0]  i_araddr   = 6'h00;
    logic        i_arvalid  = 1'b0;
    logic        i_rready   = 1'b0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic [31:0] o_rdata;
    int          fails     = 0;
    int          cmp_count = 0;
    logic [31:0] lfsr      = 32'h237E9808;
    int          m[7];

    always #25 i_core_clk = ~i_core_clk;

    // Short prescaler: one second is 256 core cycles
    rtc_calendar_counters #(.TICK_CYCLES(2)) u_rtc_calendar_counters (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));

    // ==========================================================================
    // Reference model: m holds sec, min, hour, weekday, date, month, year in decimal
    function automatic logic [31:0] to_bcd(input int v);
        return 32'((v / 10) * 16 + v % 10);
    endfunction

    function automatic int month_len(input int mo, input int yr);
        if (mo == 2) begin
            return (yr % 4 == 0) ? 29 : 28;
        end
        if (mo == 4 || mo == 6 || mo == 9 || mo == 11) begin
            return 30;
        end
        return 31;
    endfunction

    function automatic void model_step();
        m[0]++;
        if (m[0] < 60) return;
        m[0] = 0;
        m[1]++;
        if (m[1] < 60) return;
        m[1] = 0;
        m[2]++;
        if (m[2] < 24) return;
        m[2] = 0;
        m[3] = (m[3] + 1) % 7;
        m[4]++;
        if (m[4] <= month_len(m[5], m[6])) return;
        m[4] = 1;
        m[5]++;
        if (m[5] <= 12) return;
        m[5] = 1;
        m[6] = (m[6] + 1) % 100;
    endfunction

    function automatic int rnd(input int range);
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
        return int'(lfsr[15:0]) % range;
    endfunction

    // ==========================================================================
    // Bus tasks and comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input int idx, input logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_awaddr  <= 6'(idx * 4);
        i_wdata   <= d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_awready !== 1'b1 && n < 100);
        i_awvalid <= 1'b0;
        i_wvalid  <= 1'b0;
        while (o_bvalid !== 1'b1 && n < 200) begin
            @(posedge i_core_clk);
            n++;
        end
        resp = o_bresp;
        i_bready <= 1'b0;
        if (n >= 100) fails++;
    endtask

    task automatic rd(input int idx, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_araddr  <= 6'(idx * 4);
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_arready !== 1'b1 && n < 100);
        i_arvalid <= 1'b0;
        while (o_rvalid !== 1'b1 && n < 200) begin
            @(posedge i_core_clk);
            n++;
        end
        d    = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
        if (n >= 100) fails++;
    endtask

    // ==========================================================================
    // Load the model's calendar, let exactly one second pass, compare all fields
    task automatic run_second(input string name);
        logic [31:0] d;
        logic [1:0]  r;
        int          k;
        wr(`RTC_IDX_CTRL, 32'h0, r);
        for (int i = 0; i < 7; i++) wr(i + 1, to_bcd(m[i]), r);
        wr(`RTC_IDX_CTRL, 32'h2, r);
        wr(`RTC_IDX_CTRL, 32'h1, r);
        k = 0;
        do begin
            rd(`RTC_IDX_SEC, d, r);
            k++;
        end while (d === to_bcd(m[0]) && k < 400);
        // Stop right after the step so no second tick slips in while reading
        wr(`RTC_IDX_CTRL, 32'h0, r);
        model_step();
        for (int i = 0; i < 7; i++) begin
            rd(i + 1, d, r);
            chk($sformatf("%s field %0d", name, i), to_bcd(m[i]), d);
        end
        $display("test %s done", name);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================================
    // Rollover cases: sec, min, hour, weekday, date, month, year
    int cases[10][7] = '{
        '{59, 59, 23, 6, 31, 12, 99}, '{59, 59, 23, 2, 28, 2, 24},
        '{59, 59, 23, 2, 28, 2, 23},  '{59, 59, 23, 3, 29, 2, 12},
        '{59, 59, 23, 1, 30, 4, 10},  '{59, 59, 23, 1, 30, 5, 10},
        '{59, 59, 22, 0, 15, 7, 5},   '{9, 0, 0, 0, 1, 1, 0},
        '{59, 9, 19, 5, 9, 9, 19},    '{59, 59, 23, 4, 31, 12, 19}};

    initial begin
        repeat (100000) @(posedge i_core_clk);
        fails++;
        $display("[FAIL] watchdog expired before the tests ended");
        conclude();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  masks[7];
        masks = '{`RTC_MASK_SEC, `RTC_MASK_MIN, `RTC_MASK_HOUR, `RTC_MASK_WDAY,
                  `RTC_MASK_DATE, `RTC_MASK_MON, `RTC_MASK_YEAR};
        repeat (3) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        rd(`RTC_IDX_CTRL, d, r);
        chk("control after reset", 32'h1, d);
        wr(`RTC_IDX_CTRL, 32'h2, r);
        rd(`RTC_IDX_DIV, d, r);
        chk("divider after clear", 32'h0, d);
        wr(`RTC_IDX_CTRL, 32'h1, r);
        repeat (40) @(posedge i_core_clk);
        wr(`RTC_IDX_CTRL, 32'h0, r);
        rd(`RTC_IDX_DIV, d, r);
        chk("divider bit 7", 32'h0, {24'h0, d[7], 7'h0});
        chk("divider advanced", 32'h1, 32'(d >= 18 && d <= 24));
        wr(`RTC_IDX_DIV, 32'h55, r);
        wr(`RTC_IDX_CTRL, 32'h4, r);
        rd(`RTC_IDX_DIV, d, r);
        chk("divider after adjust", 32'h0, d);
        $display("test divider done");
        for (int i = 0; i < 7; i++) begin
            wr(i + 1, 32'hFF, r);
            rd(i + 1, d, r);
            chk($sformatf("mask field %0d", i), {24'h0, masks[i]}, d);
        end
        wr(9, 32'h12, r);
        chk("unmapped write resp", 32'(`RTC_RESP_SLVERR), 32'(r));
        rd(9, d, r);
        chk("unmapped read resp", 32'(`RTC_RESP_SLVERR), 32'(r));
        chk("unmapped read data", 32'h0, d);
        $display("test masks and unmapped done");
        for (int c = 0; c < 10; c++) begin
            m = cases[c];
            run_second($sformatf("rollover %0d", c));
        end
        for (int c = 0; c < 3; c++) begin
            m = '{rnd(59), rnd(60), rnd(24), rnd(7), rnd(28) + 1, rnd(12) + 1, rnd(100)};
            run_second($sformatf("random %0d", c));
        end
        m = '{33, 44, 11, 3, 17, 8, 48};
        for (int i = 0; i < 7; i++) wr(i + 1, to_bcd(m[i]), r);
        wr(`RTC_IDX_CTRL, 32'h2, r);
        @(posedge i_core_clk);
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(i + 1, d, r);
            chk($sformatf("kept field %0d", i), to_bcd(m[i]), d);
        end
        $display("test reset retention done");
        conclude();
    end

endmodule
